// file: inc/fof_pkg.sv
// package of field layout, class codes and constants for the operand format block
package fof_pkg;
  localparam int HALF_W   = 16;      // bus width
  localparam int WORD_W   = 32;      // word width
  localparam int SIGN_BIT = 31;      // sign position
  localparam int EXP_HI   = 30;      // exponent top bit
  localparam int EXP_LO   = 23;      // exponent bottom bit
  localparam int EXP_W    = 8;       // exponent width
  localparam int FRAC_HI  = 22;      // fraction top bit
  localparam int FRAC_W   = 23;      // fraction width
  localparam int SIG_W    = 24;      // significand width
  localparam int EEXP_W   = 9;       // signed effective exponent width
  localparam logic [EXP_W-1:0]  EXP_ALL_ONE  = 8'hff;   // special exponent
  localparam logic [EXP_W-1:0]  EXP_ALL_ZERO = 8'h00;   // zero/denormal exponent
  localparam logic [FRAC_W-1:0] FRAC_ZERO    = 23'h000000; // empty fraction
  localparam logic [EEXP_W-1:0] EXP_BIAS     = 9'h07f;  // bias 127
  localparam logic [EEXP_W-1:0] EXP_MIN      = 9'h182;  // -126 two's complement
  localparam logic [WORD_W-1:0] WORD_RST     = 32'h00000000; // reset word
  localparam logic [HALF_W-1:0] HALF_RST     = 16'h0000; // reset half

  // word classes
  typedef enum logic [2:0] {
    FOF_ZERO, FOF_DENORM, FOF_NORM, FOF_INF, FOF_NAN
  } fof_class_t;
endpackage : fof_pkg

// file: src/fof_half_reg.sv
// holds the captured most significant half until its partner arrives
module fof_half_reg
  import fof_pkg::*;
(
  input  wire logic              clk_sys, // clock
  input  wire logic              srst,    // sync reset
  input  wire logic              wr_en,   // capture strobe
  input  wire logic [HALF_W-1:0] wr_data, // half to capture
  output logic      [HALF_W-1:0] rd_data  // registered half
);
  logic [HALF_W-1:0] half_q; // stored half

  // store on strobe, clear on reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      half_q <= HALF_RST;
    end else if (wr_en) begin
      half_q <= wr_data;
    end
  end
  assign rd_data = half_q;
endmodule : fof_half_reg

// file: src/fof_format.sv
// operand word assembly, field split, classification and quotient word split
// Functional notes
// - words cross 16-bit buses in two halves
// - bit 31 is sign, high negative
// - bits 30..23 are biased exponent
// - fraction plus hidden bit forms 24 bits
// - all-ones exponent, zero fraction is infinity
// - all-ones exponent, nonzero fraction is NaN
// - zero exponent and fraction is zero
// - both zero signs treated the same
// - denormal: hidden zero, exponent -126
// - normal: hidden one, exponent minus 127
// - exponent codes 0 and 1 give -126
module fof_format
  import fof_pkg::*;
(
  input  wire logic               clk_sys,    // clock, 250 MHz
  input  wire logic               srst,       // sync reset, active high
  input  wire logic               in_valid,   // input half present
  input  wire logic               in_first,   // this half is the high half
  input  wire logic [HALF_W-1:0]  in_half,    // input bus half
  input  wire logic               q_load,     // quotient word to send
  input  wire logic [WORD_W-1:0]  q_word,     // quotient word
  output logic                    op_valid,   // decoded word pulse
  output logic      [WORD_W-1:0]  op_word,    // assembled word
  output logic                    op_sign,    // sign, zero forced positive
  output logic      [EXP_W-1:0]   op_exp,     // raw exponent field
  output logic      [SIG_W-1:0]   op_sig,     // significand with hidden bit
  output logic      [EEXP_W-1:0]  op_eexp,    // signed effective exponent
  output fof_class_t              op_class,   // word class
  output logic                    out_valid,  // output half present
  output logic                    out_first,  // output half is high half
  output logic      [HALF_W-1:0]  out_half    // output bus half
);

  // pick class from the exponent and fraction fields
  function automatic fof_class_t classify(input logic [WORD_W-1:0] w);
    logic [EXP_W-1:0]  e;
    logic [FRAC_W-1:0] f;
    e = w[EXP_HI:EXP_LO];
    f = w[FRAC_HI:0];
    if (e == EXP_ALL_ONE) begin
      classify = (f == FRAC_ZERO) ? FOF_INF : FOF_NAN;
    end else if (e == EXP_ALL_ZERO) begin
      classify = (f == FRAC_ZERO) ? FOF_ZERO : FOF_DENORM;
    end else begin
      classify = FOF_NORM;
    end
  endfunction : classify

  logic              hi_seen_q; // high half waiting
  logic [HALF_W-1:0] hi_half;   // stored high half
  logic              hi_wr;     // capture high half
  logic              lo_take;   // low half completes a word
  logic [WORD_W-1:0] word_d;    // assembled word
  fof_class_t        cls_d;     // class of assembled word
  logic [EXP_W-1:0]  exp_d;     // exponent field
  logic [WORD_W-1:0] qbuf_q;    // quotient awaiting low half
  logic              qlow_q;    // low half due next cycle

  assign hi_wr   = in_valid && in_first;
  assign lo_take = in_valid && !in_first && hi_seen_q;

  fof_half_reg u_hi (
    .clk_sys (clk_sys),
    .srst    (srst),
    .wr_en   (hi_wr),
    .wr_data (in_half),
    .rd_data (hi_half)
  );

  // track whether a high half is waiting; a stray low half is dropped
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hi_seen_q <= 1'b0;
    end else if (in_valid) begin
      hi_seen_q <= in_first;
    end else begin
      hi_seen_q <= 1'b0;     // halves must be consecutive
    end
  end

  assign word_d = {hi_half, in_half};
  assign cls_d  = classify(word_d);
  assign exp_d  = word_d[EXP_HI:EXP_LO];

  // decode the assembled word in one step
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_valid <= 1'b0;
      op_word  <= WORD_RST;
      op_sign  <= 1'b0;
      op_exp   <= EXP_ALL_ZERO;
      op_sig   <= {SIG_W{1'b0}};
      op_eexp  <= EXP_MIN;
      op_class <= FOF_ZERO;
    end else begin
      op_valid <= lo_take;
      if (lo_take) begin
        op_word  <= word_d;
        // zero sign dropped so both zeros give the same op_sign downstream
        op_sign  <= word_d[SIGN_BIT] && (cls_d != FOF_ZERO);
        op_exp   <= exp_d;
        // hidden bit set for any nonzero exponent
        op_sig   <= {(exp_d != EXP_ALL_ZERO), word_d[FRAC_HI:0]};
        op_eexp  <= (exp_d == EXP_ALL_ZERO) ? EXP_MIN
                    : ({1'b0, exp_d} - EXP_BIAS);
        op_class <= cls_d;
      end
    end
  end

  // quotient out: high half on load, low half on the following cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      qbuf_q    <= WORD_RST;
      qlow_q    <= 1'b0;
      out_valid <= 1'b0;
      out_first <= 1'b0;
      out_half  <= HALF_RST;
    end else if (q_load && !qlow_q) begin
      qbuf_q    <= q_word;
      qlow_q    <= 1'b1;
      out_valid <= 1'b1;
      out_first <= 1'b1;
      out_half  <= q_word[WORD_W-1:HALF_W];
    end else if (qlow_q) begin
      qlow_q    <= 1'b0;
      out_valid <= 1'b1;
      out_first <= 1'b0;
      out_half  <= qbuf_q[HALF_W-1:0];
    end else begin
      out_valid <= 1'b0;
      out_first <= 1'b0;
    end
  end

  // checks on the decode path and the quotient split; all are held off
  // while reset is high, so the cleared state never trips them

  // a high half followed at once by a low half always yields a decode
  AST_DECODE_LAT: assert property (@(posedge clk_sys) disable iff (srst)
    (in_valid && in_first) ##1 (in_valid && !in_first) |=> op_valid)
    else $error("word not decoded after two halves");

  // a decode always traces back to a high half two cycles earlier
  AST_NO_LONE: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid |-> $past(in_valid, 2) && $past(in_first, 2))
    else $error("decode without high half");

  // all-ones exponent with empty fraction is infinity
  AST_INF: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_exp == EXP_ALL_ONE && op_sig[FRAC_HI:0] == FRAC_ZERO
      |-> op_class == FOF_INF)
    else $error("infinity misclassified");

  // all-ones exponent with any fraction bit set is not a number
  AST_NAN: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_exp == EXP_ALL_ONE && op_sig[FRAC_HI:0] != FRAC_ZERO
      |-> op_class == FOF_NAN)
    else $error("nan misclassified");

  // empty exponent and fraction is zero, shown positive
  AST_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_word[EXP_HI:0] == 31'h00000000 |-> op_class == FOF_ZERO && !op_sign)
    else $error("zero misclassified or signed");

  // every nonzero word carries its top bit as sign
  AST_SIGN: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_class != FOF_ZERO |-> op_sign == op_word[SIGN_BIT])
    else $error("sign not bit 31");

  // hidden bit follows the exponent being nonzero
  AST_HIDDEN: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid |-> op_sig[SIG_W-1] == (op_exp != EXP_ALL_ZERO))
    else $error("hidden bit wrong");

  // stored fraction passes through untouched below the hidden bit
  AST_FRAC: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid |-> op_sig[FRAC_HI:0] == op_word[FRAC_HI:0])
    else $error("fraction field wrong");

  // raw exponent is the field just below the sign
  AST_EXP_FIELD: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid |-> op_exp == op_word[EXP_HI:EXP_LO])
    else $error("exponent field wrong");

  // codes zero and one share the smallest effective exponent
  AST_EXP_MIN: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_exp <= 8'h01 |-> op_eexp == EXP_MIN)
    else $error("low exponent codes not -126");

  // denormals get a clear hidden bit and the smallest exponent
  AST_DENORM: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_class == FOF_DENORM |-> !op_sig[SIG_W-1] && op_eexp == EXP_MIN)
    else $error("denormal decoded wrong");

  // both zeros leave identical sign and significand downstream
  AST_ZERO_SAME: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_class == FOF_ZERO |-> !op_sign && op_sig == {SIG_W{1'b0}})
    else $error("signed zeros differ");

  // normal exponent is the field less the bias
  AST_NORM: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid && op_class == FOF_NORM |-> op_eexp == ({1'b0, op_exp} - EXP_BIAS))
    else $error("normal exponent unbiased wrong");

  // a decode lasts one cycle; two words need at least two cycles apart
  AST_OP_PULSE: assert property (@(posedge clk_sys) disable iff (srst)
    op_valid |=> !op_valid)
    else $error("decode pulse too long");

  // a low half with no high half waiting is dropped
  AST_STRAY: assert property (@(posedge clk_sys) disable iff (srst)
    in_valid && !in_first && !hi_seen_q |=> !op_valid)
    else $error("stray low half decoded");

  // quotient goes out high half first, low half next
  AST_Q_SPLIT: assert property (@(posedge clk_sys) disable iff (srst)
    q_load && !qlow_q |=> out_first && out_half == $past(q_word[WORD_W-1:HALF_W])
      ##1 out_valid && !out_first && out_half == $past(q_word[HALF_W-1:0], 2))
    else $error("quotient halves wrong");

  // the low-half cycle cannot be cut short by a new load
  AST_Q_LOW: assert property (@(posedge clk_sys) disable iff (srst)
    qlow_q |=> out_valid && !out_first)
    else $error("low quotient half lost");
endmodule : fof_format

// file: test/fof_host_model.sv
// host model that feeds operand words to the block as two bus halves
module fof_host_model
  import fof_pkg::*;
(
  input  wire logic              clk_sys,  // clock
  output logic                   in_valid, // half present
  output logic                   in_first, // high half flag
  output logic      [HALF_W-1:0] in_half   // bus half
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    in_valid = 1'b0;
    in_first = 1'b0;
    in_half  = 16'h0000;
  end
  // high half then low half on consecutive cycles; lone sends a stray low half
  task automatic send(input logic [WORD_W-1:0] w, input logic lone);
    if (!lone) begin
      @(negedge clk_sys);
      in_valid = 1'b1;
      in_first = 1'b1;
      in_half  = w[31:16];
    end
    @(negedge clk_sys);
    in_valid = 1'b1;
    in_first = 1'b0;
    in_half  = w[15:0];
    @(negedge clk_sys);
    in_valid = 1'b0;
    in_half  = ~w[15:0];     // released bus shows inverse, never stale data
  endtask : send
  // a high half left alone, bus idle on the next cycle
  task automatic send_hi(input logic [HALF_W-1:0] h);
    @(negedge clk_sys);
    in_valid = 1'b1;
    in_first = 1'b1;
    in_half  = h;
    @(negedge clk_sys);
    in_valid = 1'b0;
    in_half  = ~h;           // released bus shows inverse
  endtask : send_hi
endmodule : fof_host_model

// file: test/float32_operand_format_tb.sv
// self-checking bench for operand decode and quotient split
module float32_operand_format_tb
  import fof_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, srst, in_valid, in_first, q_load, op_valid, op_sign, out_valid, out_first;
  logic [15:0] in_half, out_half;  // bus halves
  logic [31:0] q_word, op_word;    // words
  logic [7:0]  op_exp;             // raw exponent
  logic [23:0] op_sig;             // significand
  logic [8:0]  op_eexp;            // effective exponent
  fof_class_t  op_class;           // class
  int seed = 94;                   // fixed seed
  int failures, n_compared, cycles;
  logic [31:0] corner [10] = '{32'h00000000, 32'h80000000, 32'h7f800000, 32'hff800000,
    32'h7fc00001, 32'h00000001, 32'h807fffff, 32'h00800000, 32'h7f7fffff, 32'h3f800000};
  fof_host_model i_fof_host_model (.clk_sys(clk_sys), .in_valid(in_valid),
    .in_first(in_first), .in_half(in_half));
  fof_format i_fof_format (.clk_sys(clk_sys), .srst(srst), .in_valid(in_valid),
    .in_first(in_first), .in_half(in_half), .q_load(q_load), .q_word(q_word),
    .op_valid(op_valid), .op_word(op_word), .op_sign(op_sign), .op_exp(op_exp),
    .op_sig(op_sig), .op_eexp(op_eexp), .op_class(op_class), .out_valid(out_valid),
    .out_first(out_first), .out_half(out_half));
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // hang guard: about 1100 cycles are expected
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  // expected class from exponent and fraction
  function automatic fof_class_t exp_cls(input logic [31:0] w);
    if (w[30:23] == 8'hff) return (w[22:0] == 23'h000000) ? FOF_INF : FOF_NAN;
    if (w[30:23] == 8'h00) return (w[22:0] == 23'h000000) ? FOF_ZERO : FOF_DENORM;
    return FOF_NORM;
  endfunction : exp_cls
  // expected effective exponent: codes 0 and 1 both give -126
  function automatic logic [8:0] exp_eexp(input logic [7:0] e);
    return (e == 8'h00) ? 9'h182 : 9'({1'b0, e} - 9'h07f);
  endfunction : exp_eexp
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // send one word and check the decode in the cycle after the low half
  task automatic run(input logic [31:0] w, input logic lone);
    i_fof_host_model.send(w, lone);
    check("op_valid", {31'h0, op_valid}, {31'h0, !lone});
    if (!lone) begin
      check("op_word", op_word, w);
      check("op_class", 32'(op_class), 32'(exp_cls(w)));
      check("op_sign", {31'h0, op_sign}, {31'h0, w[31] & (w[30:0] != 31'h0)});
      check("op_exp", {24'h0, op_exp}, {24'h0, w[30:23]});
      check("op_sig", {8'h0, op_sig}, {8'h0, w[30:23] != 8'h00, w[22:0]});
      check("op_eexp", {23'h0, op_eexp}, {23'h0, exp_eexp(w[30:23])});
    end
  endtask : run
  // quotient word leaves as high half then low half; hold keeps q_load up
  // into the low-half cycle, where the block must refuse it
  task automatic qsend(input logic [31:0] w, input logic hold);
    @(negedge clk_sys);
    q_load = 1'b1;
    q_word = w;
    @(negedge clk_sys);
    q_load = hold;
    q_word = ~w;
    check("out_hi", {14'h0, out_valid, out_first, out_half}, {16'h3, w[31:16]});
    @(negedge clk_sys);
    q_load = 1'b0;
    check("out_lo", {14'h0, out_valid, out_first, out_half}, {16'h2, w[15:0]});
    @(negedge clk_sys);
    check("out_idle", {30'h0, out_valid, out_first}, 32'h0);
  endtask : qsend
  // outputs after reset take their cleared values
  task automatic rst_check();
    check("rst_valid", {30'h0, op_valid, out_valid}, 32'h0);
    check("rst_word", op_word, 32'h0);
    check("rst_class", 32'(op_class), 32'(FOF_ZERO));
    check("rst_eexp", {23'h0, op_eexp}, 32'h00000182);
  endtask : rst_check
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // reset, corner words, stray half, random words, quotient words
  initial begin
    srst = 1'b1;
    q_load = 1'b0;
    q_word = 32'h00000000;
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    rst_check();
    foreach (corner[i]) run(corner[i], 1'b0);
    run(32'h12345678, 1'b1); // stray low half dropped
    check("op_hold", op_word, corner[9]);
    // reset in mid-run must clear the decoded word
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    rst_check();
    // high half followed by idle: the late low half is dropped
    i_fof_host_model.send_hi(16'h3f80);
    run(32'h3f800000, 1'b1);
    for (int i = 0; i < 300; i++) run($random(seed), 1'b0);
    for (int i = 0; i < 30; i++) qsend($random(seed), i[0]);
    results();
  end
endmodule : float32_operand_format_tb
